/* src/pcdl_defines.svh */
`ifndef PCDL_DEFINES_SVH
`define PCDL_DEFINES_SVH

// geometry
`define PCDL_STAGES 192
`define PCDL_HALF 96
`define PCDL_LANES 6
`define PCDL_WORDS 6

// apb byte offsets
`define PCDL_OFS_CTRL 8'h00
`define PCDL_OFS_STATUS 8'h04
`define PCDL_OFS_IDX 8'h08
`define PCDL_OFS_DATA 8'h0c

// ctrl fields
`define PCDL_CTRL_SOFT_CLR 0

// status fields
`define PCDL_ST_SHIFTS_LSB 0
`define PCDL_ST_MODE_LSB 16
`define PCDL_ST_DIR 18
`define PCDL_ST_LATCHES_LSB 24

// reset values
`define PCDL_IDX_RST 3'h0
`define PCDL_SHIFTS_RST 16'h0000
`define PCDL_LATCHES_RST 8'h00

`endif

/* src/pcdl_pkg.sv */
package pcdl_pkg;

  // lane arrangement selected by the two mode pins
  typedef enum logic [1:0] {
    PCDL_THREE = 2'b00,
    PCDL_SIX_WEAVE = 2'b01,
    PCDL_SIX_SPLIT = 2'b10
  } pcdl_mode_t;

  // output override controls, sampled together
  typedef struct packed {
    logic output_float;
    logic force_low_n;
    logic force_high_n;
  } pcdl_ovr_t;

  // decoded apb access
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } pcdl_acc_t;

endpackage

/* src/pcdl_latch_bank.sv */
`timescale 1ns/1ps
`include "pcdl_defines.svh"

module pcdl_latch_bank #(
  parameter int WORDS = `PCDL_WORDS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // capture side
  input wire logic capture,
  input wire logic [WORDS*32-1:0] cap_data,
  // full contents for the column drivers
  output logic [WORDS*32-1:0] held,
  // word read port
  input wire logic [2:0] rd_idx,
  output logic [31:0] rd_word
);

  logic [WORDS*32-1:0] held_d;
  logic [31:0] rd_word_d;

  // capture on strobe, otherwise hold; word read registered
  always_comb begin
    held_d = capture ? cap_data : held;
    rd_word_d = 32'h0000_0000;
    if (int'(rd_idx) < WORDS) begin
      rd_word_d = held[rd_idx*32 +: 32];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      held <= '0;
      rd_word <= 32'h0000_0000;
    end else begin
      held <= held_d;
      rd_word <= rd_word_d;
    end
  end

endmodule

/* src/pcdl_column_driver.sv */
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "pcdl_defines.svh"

module pcdl_column_driver (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pixel link
  input wire logic xfer_clk,
  input wire logic [5:0] serial_lane_in,
  input wire logic shift_right,
  input wire logic edge_select,
  input wire logic lane_mode_sel_a,
  input wire logic lane_mode_sel_b,
  input wire logic latch_strobe_n,
  input wire logic chain_clear_n,
  // output overrides
  input wire logic output_float,
  input wire logic force_low_n,
  input wire logic force_high_n,
  // column outputs
  output logic [191:0] column_outputs,
  output logic [191:0] column_oe,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int NS = `PCDL_STAGES;
  localparam int NH = `PCDL_HALF;

  pcdl_pkg::pcdl_mode_t mode;
  pcdl_pkg::pcdl_ovr_t ovr;
  pcdl_pkg::pcdl_acc_t acc;
  logic [NS-1:0] chain_q, chain_d, shifted;
  logic xfer_prev_q, xfer_prev_d;
  logic strobe_prev_q, strobe_prev_d;
  logic xfer_edge, strobe_fall, soft_clr;
  logic [NS-1:0] latched;
  logic [31:0] latch_word;
  logic [191:0] col_out_d, col_oe_d;
  logic [2:0] idx_q, idx_d;
  logic [15:0] shifts_q, shifts_d;
  logic [7:0] latches_q, latches_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic acc_take, acc_done;

  // lane mode decode
  always_comb begin
    if (!lane_mode_sel_a) begin
      mode = pcdl_pkg::PCDL_THREE;
    end else if (lane_mode_sel_b) begin
      mode = pcdl_pkg::PCDL_SIX_SPLIT;
    end else begin
      mode = pcdl_pkg::PCDL_SIX_WEAVE;
    end
  end

  // next value of one stage within a segment [lo,hi) with a given lane stride
  function automatic logic pick(input logic [NS-1:0] ch, input logic [5:0] ln,
                                input int i, input int lo, input int hi,
                                input int st, input int loff, input logic rgt);
    logic r;
    r = 1'b0;
    if (rgt) begin
      if (i - lo < st) r = ln[loff + i - lo];
      else r = ch[i - st];
    end else begin
      if (hi - 1 - i < st) r = ln[loff + i - (hi - st)];
      else r = ch[i + st];
    end
    return r;
  endfunction

  // per-stage shift source for each lane arrangement
  for (genvar g = 0; g < NS; g++) begin : g_stage
    localparam int LO = (g >= NH) ? NH : 0;
    localparam int OFF = (g >= NH) ? 3 : 0;
    always_comb begin
      unique case (mode)
        pcdl_pkg::PCDL_SIX_SPLIT: shifted[g] = pick(chain_q, serial_lane_in, g, LO, LO + NH,
                                                    3, OFF, shift_right);
        pcdl_pkg::PCDL_SIX_WEAVE: shifted[g] = pick(chain_q, serial_lane_in, g, 0, NS,
                                                    6, 0, shift_right);
        pcdl_pkg::PCDL_THREE: shifted[g] = pick(chain_q, serial_lane_in, g, 0, NS,
                                                3, 0, shift_right);
        default: shifted[g] = chain_q[g];
      endcase
    end
  end

  // transfer clock and strobe edge detection
  always_comb begin
    xfer_prev_d = xfer_clk;
    strobe_prev_d = latch_strobe_n;
    if (edge_select) begin
      xfer_edge = xfer_clk ^ xfer_prev_q;
    end else begin
      xfer_edge = xfer_clk & ~xfer_prev_q;
    end
    strobe_fall = strobe_prev_q & ~latch_strobe_n;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      xfer_prev_q <= 1'b0;
      strobe_prev_q <= 1'b1;
    end else begin
      xfer_prev_q <= xfer_prev_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  // shift chain next value
  always_comb begin
    if (soft_clr) begin
      chain_d = '0;
    end else if (xfer_edge) begin
      chain_d = shifted;
    end else begin
      chain_d = chain_q;
    end
  end

  // chain clear acts without the clock and wins over shifting
  always_ff @(posedge mclk or negedge chain_clear_n) begin
    if (!chain_clear_n) begin
      chain_q <= '0;
    end else if (reset) begin
      chain_q <= '0;
    end else begin
      chain_q <= chain_d;
    end
  end

  // output latch; untouched by chain clear
  pcdl_latch_bank #(
    .WORDS(`PCDL_WORDS)
  ) u_latch (
    .mclk(mclk),
    .reset(reset),
    .capture(strobe_fall),
    .cap_data(chain_q),
    .held(latched),
    .rd_idx(idx_q),
    .rd_word(latch_word)
  );

  // column drive with override priority
  always_comb begin
    ovr = '{output_float: output_float, force_low_n: force_low_n,
            force_high_n: force_high_n};
    if (ovr.output_float) begin
      col_out_d = '0;
      col_oe_d = '0;
    end else if (!ovr.force_low_n) begin
      col_out_d = '0;
      col_oe_d = '1;
    end else if (!ovr.force_high_n) begin
      col_out_d = '1;
      col_oe_d = '1;
    end else begin
      col_out_d = latched;
      col_oe_d = '1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      column_outputs <= '0;
      column_oe <= '0;
    end else begin
      column_outputs <= col_out_d;
      column_oe <= col_oe_d;
    end
  end

  // apb slave: pready one cycle into access, writes land at completion
  always_comb begin
    acc = '{addr: paddr, write: pwrite, wdata: pwdata};
    acc_take = psel & penable & ~pready;
    acc_done = psel & penable & pready;
    soft_clr = acc_done & acc.write & (acc.addr == `PCDL_OFS_CTRL) &
               acc.wdata[`PCDL_CTRL_SOFT_CLR];
    pready_d = acc_take;
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    idx_d = idx_q;
    if (acc_done && acc.write && acc.addr == `PCDL_OFS_IDX) begin
      idx_d = acc.wdata[2:0];
    end
    if (acc_take) begin
      unique case (acc.addr)
        `PCDL_OFS_CTRL: prdata_d = 32'h0000_0000;
        `PCDL_OFS_STATUS: begin
          prdata_d[`PCDL_ST_SHIFTS_LSB +: 16] = shifts_q;
          prdata_d[`PCDL_ST_MODE_LSB +: 2] = mode;
          prdata_d[`PCDL_ST_DIR] = shift_right;
          prdata_d[`PCDL_ST_LATCHES_LSB +: 8] = latches_q;
        end
        `PCDL_OFS_IDX: prdata_d = {29'h0000_0000, idx_q};
        `PCDL_OFS_DATA: prdata_d = latch_word;
        default: pslverr_d = 1'b1;
      endcase
    end else if (pready) begin
      prdata_d = prdata;
    end
  end

  // activity counters: shifts since last latch, latches taken
  always_comb begin
    shifts_d = shifts_q;
    latches_d = latches_q;
    if (strobe_fall) begin
      // a shift in the strobe edge lands after the capture, so it counts
      shifts_d = (xfer_edge && chain_clear_n && !soft_clr) ? 16'h0001 : `PCDL_SHIFTS_RST;
      latches_d = latches_q + 8'h01;
    end else if (xfer_edge && chain_clear_n && !soft_clr) begin
      shifts_d = shifts_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      idx_q <= `PCDL_IDX_RST;
      shifts_q <= `PCDL_SHIFTS_RST;
      latches_q <= `PCDL_LATCHES_RST;
    end else begin
      pready <= pready_d;
      prdata <= prdata_d;
      pslverr <= pslverr_d;
      idx_q <= idx_d;
      shifts_q <= shifts_d;
      latches_q <= latches_d;
    end
  end

  // checks
  property p_force_low;
    @(posedge mclk) disable iff (reset)
      (!output_float && !force_low_n) |=> (column_outputs == '0 && column_oe == '1);
  endproperty
  a_force_low: assert property (p_force_low) else $error("force low not applied");

  property p_force_high;
    @(posedge mclk) disable iff (reset)
      (!output_float && force_low_n && !force_high_n) |=>
        (column_outputs == '1 && column_oe == '1);
  endproperty
  a_force_high: assert property (p_force_high) else $error("force high not applied");

  property p_float;
    @(posedge mclk) disable iff (reset)
      output_float |=> (column_oe == '0);
  endproperty
  a_float: assert property (p_float) else $error("outputs not floated");

  property p_pass;
    @(posedge mclk) disable iff (reset)
      (!output_float && force_low_n && force_high_n) |=> (column_outputs == $past(latched));
  endproperty
  a_pass: assert property (p_pass) else $error("outputs do not follow latch");

  property p_latch;
    @(posedge mclk) disable iff (reset)
      (strobe_prev_q && !latch_strobe_n) |=> (latched == $past(chain_q));
  endproperty
  a_latch: assert property (p_latch) else $error("latch missed strobe fall");

  property p_latch_hold;
    @(posedge mclk) disable iff (reset)
      !(strobe_prev_q && !latch_strobe_n) |=> $stable(latched);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without strobe");

  property p_clear;
    @(posedge mclk) disable iff (reset)
      (!chain_clear_n && !$past(chain_clear_n)) |-> (chain_q == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("chain not cleared");

  property p_double_fall;
    @(posedge mclk) disable iff (reset)
      (edge_select && xfer_prev_q && !xfer_clk && chain_clear_n && !soft_clr &&
       !shift_right && mode == pcdl_pkg::PCDL_THREE) |=>
        (!chain_clear_n || (chain_q[189] == $past(serial_lane_in[0]) &&
                            chain_q[0] == $past(chain_q[3])));
  endproperty
  a_double_fall: assert property (p_double_fall) else $error("no shift on falling edge");

  property p_single_hold;
    @(posedge mclk) disable iff (reset)
      (!edge_select && !(xfer_clk && !xfer_prev_q) && chain_clear_n && !soft_clr) |=>
        (!chain_clear_n || $stable(chain_q));
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("shift without rising edge");

  property p_weave_left;
    @(posedge mclk) disable iff (reset)
      (xfer_edge && !soft_clr && chain_clear_n && !shift_right &&
       mode == pcdl_pkg::PCDL_SIX_WEAVE) |=>
        (!chain_clear_n || (chain_q[186] == $past(serial_lane_in[0]) &&
                            chain_q[0] == $past(chain_q[6])));
  endproperty
  a_weave_left: assert property (p_weave_left) else $error("weave left shift wrong");

  property p_split_right;
    @(posedge mclk) disable iff (reset)
      (xfer_edge && !soft_clr && chain_clear_n && shift_right &&
       mode == pcdl_pkg::PCDL_SIX_SPLIT) |=>
        (!chain_clear_n || (chain_q[96] == $past(serial_lane_in[3]) &&
                            chain_q[99] == $past(chain_q[96]) &&
                            chain_q[95] == $past(chain_q[92])));
  endproperty
  a_split_right: assert property (p_split_right) else $error("split right shift wrong");

  c_latch: cover property (@(posedge mclk) disable iff (reset)
    strobe_prev_q && !latch_strobe_n);
  c_double: cover property (@(posedge mclk) disable iff (reset)
    edge_select && xfer_edge && !xfer_clk);
  c_split: cover property (@(posedge mclk) disable iff (reset)
    xfer_edge && mode == pcdl_pkg::PCDL_SIX_SPLIT);
  c_apb_rd: cover property (@(posedge mclk) disable iff (reset)
    pready && !pslverr && paddr == `PCDL_OFS_DATA);

endmodule

/* sim/pcdl_pixel_ctl.sv */
`timescale 1ns/1ps

// display controller model driving the pixel link
module pcdl_pixel_ctl (
  // clock
  input wire logic mclk,
  // pixel link
  output logic xfer_clk,
  output logic [5:0] serial_lane_in,
  output logic latch_strobe_n
);
  // link idles low, strobe idles high
  initial begin
    xfer_clk = 1'b0;
    serial_lane_in = 6'h00;
    latch_strobe_n = 1'b1;
  end

  // one transfer; every level held two mclk so no edge is lost
  task automatic send(input logic [5:0] ln, input logic three, input logic both);
    logic [5:0] v;
    v = three ? {3'h0, ln[2:0]} : ln;
    @(posedge mclk);
    serial_lane_in <= v;
    xfer_clk <= both ? ~xfer_clk : 1'b1;
    repeat (2) @(posedge mclk);
    if (!both) begin
      // low half: lines show the inverse, so a stray fall would show
      serial_lane_in <= three ? {3'h0, ~v[2:0]} : ~v;
      xfer_clk <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask

  // one falling strobe edge
  task automatic strobe();
    @(posedge mclk);
    latch_strobe_n <= 1'b0;
    repeat (2) @(posedge mclk);
    latch_strobe_n <= 1'b1;
  endtask
endmodule

/* sim/tb_panel_column_shift_latch_driver.sv */
`timescale 1ns/1ps
`include "pcdl_defines.svh"

module tb_panel_column_shift_latch_driver;
  localparam logic [191:0] ONES = '1;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic shift_right = 1'b1;
  logic edge_select = 1'b0;
  logic sel_a = 1'b0;
  logic sel_b = 1'b0;
  logic chain_clear_n = 1'b1;
  logic output_float = 1'b0;
  logic force_low_n = 1'b1;
  logic force_high_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire logic xfer_clk;
  wire logic [5:0] lanes;
  wire logic strobe_n;
  logic [191:0] column_outputs;
  logic [191:0] column_oe;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [191:0] chain_ref = '0;
  logic [191:0] lat_ref = '0;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checks = 0;
  int nlat = 0;
  int cyc = 0;

  always #12.5 mclk = ~mclk;

  pcdl_pixel_ctl ctl (
    .mclk(mclk),
    .xfer_clk(xfer_clk),
    .serial_lane_in(lanes),
    .latch_strobe_n(strobe_n)
  );

  pcdl_column_driver dut (
    .mclk(mclk),
    .reset(reset),
    .xfer_clk(xfer_clk),
    .serial_lane_in(lanes),
    .shift_right(shift_right),
    .edge_select(edge_select),
    .lane_mode_sel_a(sel_a),
    .lane_mode_sel_b(sel_b),
    .latch_strobe_n(strobe_n),
    .chain_clear_n(chain_clear_n),
    .output_float(output_float),
    .force_low_n(force_low_n),
    .force_high_n(force_high_n),
    .column_outputs(column_outputs),
    .column_oe(column_oe),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(string nm, logic [191:0] exp, logic [191:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // reference chain step: stride st, segment length seg
  function automatic logic [191:0] step(logic [191:0] v, logic [5:0] ln, int st, int seg,
                                        logic r);
    int lo;
    for (int b = 0; b < 192; b += seg) begin
      lo = (b == 96) ? 3 : 0;
      if (r) begin
        for (int i = seg - 1; i >= st; i--)
          v[b+i] = v[b+i-st];
        for (int k = 0; k < st; k++)
          v[b+k] = ln[lo+k];
      end else begin
        for (int i = 0; i < seg - st; i++)
          v[b+i] = v[b+i+st];
        for (int k = 0; k < st; k++)
          v[b+seg-st+k] = ln[lo+k];
      end
    end
    return v;
  endfunction

  // apb master: hold request until pready sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // full fill in one mode, status check, latch, column check
  task automatic fill(input logic a, b, r, e, input int n, input logic [1:0] md);
    logic [5:0] ln;
    @(posedge mclk);
    sel_a <= a;
    sel_b <= b;
    shift_right <= r;
    edge_select <= e;
    for (int j = 0; j < n; j++) begin
      ln = 6'((j * 37 + 5) ^ (j >> 2));
      ctl.send(ln, !a, e);
      chain_ref = step(chain_ref, ln, (a && !b) ? 6 : 3, (a && b) ? 96 : 192, r);
    end
    apb(1'b0, `PCDL_OFS_STATUS, 32'h0);
    chk("status", 192'({nlat[7:0], 5'h0, r, md, 16'(n)}), 192'(rd));
    ctl.strobe();
    nlat++;
    lat_ref = chain_ref;
    repeat (3) @(posedge mclk);
    chk("column_outputs", lat_ref, column_outputs);
    chk("column_oe", ONES, column_oe);
  endtask

  task automatic t_modes();
    fill(1'b0, 1'b0, 1'b1, 1'b0, 64, 2'b00);
    fill(1'b0, 1'b1, 1'b0, 1'b1, 64, 2'b00);
    fill(1'b1, 1'b0, 1'b1, 1'b1, 32, 2'b01);
    fill(1'b1, 1'b0, 1'b0, 1'b0, 32, 2'b01);
    fill(1'b1, 1'b1, 1'b1, 1'b0, 32, 2'b10);
    fill(1'b1, 1'b1, 1'b0, 1'b1, 32, 2'b10);
  endtask

  // every override combination
  task automatic t_over();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      @(posedge mclk);
      output_float <= c[2];
      force_low_n <= c[1];
      force_high_n <= c[0];
      repeat (3) @(posedge mclk);
      chk("column_oe", c[2] ? '0 : ONES, column_oe);
      if (!c[2])
        chk("column_outputs", !c[1] ? '0 : !c[0] ? ONES : lat_ref, column_outputs);
    end
    @(posedge mclk);
    output_float <= 1'b0;
  endtask

  task automatic t_apb();
    apb(1'b1, `PCDL_OFS_IDX, 32'h2);
    apb(1'b0, `PCDL_OFS_IDX, 32'h0);
    chk("idx", 192'h2, 192'(rd));
    apb(1'b0, `PCDL_OFS_DATA, 32'h0);
    chk("data_w2", 192'(lat_ref[95:64]), 192'(rd));
    chk("data_err", 192'h0, 192'(err));
    apb(1'b1, `PCDL_OFS_IDX, 32'h6);
    apb(1'b0, `PCDL_OFS_DATA, 32'h0);
    chk("data_w6", 192'h0, 192'(rd));
    apb(1'b1, 8'h10, 32'h0);
    chk("unmapped_err", 192'h1, 192'(err));
    apb(1'b0, `PCDL_OFS_CTRL, 32'h0);
    chk("ctrl", 192'h0, 192'(rd));
  endtask

  // clear beats shifting and leaves the latch alone
  task automatic t_clear();
    @(posedge mclk);
    chain_clear_n <= 1'b0;
    for (int j = 0; j < 4; j++)
      ctl.send(6'h3f, 1'b0, 1'b1);
    @(posedge mclk);
    chain_clear_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("columns_kept", lat_ref, column_outputs);
    ctl.strobe();
    repeat (3) @(posedge mclk);
    chk("columns_cleared", '0, column_outputs);
    // refill a little, then clear the chain from software
    chain_ref = '0;
    for (int j = 0; j < 4; j++) begin
      ctl.send(6'h3f, 1'b0, 1'b1);
      chain_ref = step(chain_ref, 6'h3f, 3, 96, 1'b0);
    end
    ctl.strobe();
    repeat (3) @(posedge mclk);
    chk("columns_refilled", chain_ref, column_outputs);
    apb(1'b1, `PCDL_OFS_CTRL, 32'h1);
    ctl.strobe();
    repeat (3) @(posedge mclk);
    chk("columns_soft_clr", '0, column_outputs);
  endtask

  initial begin
    repeat (19) @(posedge mclk);
    chk("reset_oe", '0, column_oe);
    @(posedge mclk);
    reset <= 1'b0;
    t_modes();
    t_over();
    t_apb();
    t_clear();
    end_sim();
  end
endmodule
